// ---- core/pioc_conn_fsm.sv ----
`timescale 1ns/1ps
// Functional notes
// - setting packet rate commits and establishes
// - explicit commit only while rate never set
// - packet rate defaults to zero
// - leaving established checks automatic set release
// - set release returns connections to nonexistent
// - allocate and release reset all attributes
// - packet rate writable by attribute write
module pioc_conn_fsm #(
  parameter int DW = 16
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic reqValid,
  input wire logic [2:0] reqOp,
  input wire logic [3:0] reqAttr,
  input wire logic [DW-1:0] reqData,
  input wire logic autoRelease,
  output logic rspValid,
  output logic rspOk,
  output logic [DW-1:0] rspData,
  output logic [1:0] connState,
  output logic setReleased,
  output logic [DW-1:0] pktRate
);

  // ****************************************
  // state and attributes
  // ****************************************
  pioc_pkg::pioc_state_t state_reg, state_next;
  logic [DW-1:0] rate_reg;
  logic [DW-1:0] size_reg;
  logic rateSet_reg;
  logic ok_next;
  logic [DW-1:0] data_next;
  logic leaveEst;
  logic goRelease;
  logic resetAttr;
  logic wrRate, wrSize;
  pioc_pkg::pioc_op_t op;

  assign op = pioc_pkg::pioc_op_t'(reqOp);

  // ****************************************
  // request decode
  // ****************************************
  always_comb begin
    state_next = state_reg;
    ok_next = 1'b0;
    data_next = '0;
    resetAttr = 1'b0;
    wrRate = 1'b0;
    wrSize = 1'b0;
    if (reqValid) begin
      unique case (op)
        pioc_pkg::OP_ALLOC: begin
          if (state_reg == pioc_pkg::ST_NONEXIST || state_reg == pioc_pkg::ST_TIMEOUT) begin
            ok_next = 1'b1;
            resetAttr = 1'b1;
            state_next = pioc_pkg::ST_CONFIG;
          end
        end
        pioc_pkg::OP_RELEASE, pioc_pkg::OP_DELETE: begin
          if (state_reg != pioc_pkg::ST_NONEXIST) begin
            ok_next = 1'b1;
            resetAttr = 1'b1;
            state_next = pioc_pkg::ST_NONEXIST;
          end
        end
        pioc_pkg::OP_SET: begin
          if (state_reg == pioc_pkg::ST_CONFIG) begin
            if (reqAttr == pioc_pkg::ATTR_PKT_RATE) begin
              ok_next = 1'b1;
              wrRate = 1'b1;
              state_next = pioc_pkg::ST_ESTAB;
            end else if (reqAttr == pioc_pkg::ATTR_PROD_SIZE) begin
              ok_next = 1'b1;
              wrSize = 1'b1;
            end
          end else if (state_reg != pioc_pkg::ST_NONEXIST &&
                       reqAttr == pioc_pkg::ATTR_PKT_RATE) begin
            ok_next = 1'b1;
            wrRate = 1'b1;
          end
        end
        pioc_pkg::OP_GET: begin
          if (state_reg != pioc_pkg::ST_NONEXIST) begin
            ok_next = 1'b1;
            if (reqAttr == pioc_pkg::ATTR_PKT_RATE) begin
              data_next = rate_reg;
            end else if (reqAttr == pioc_pkg::ATTR_PROD_SIZE) begin
              data_next = size_reg;
            end else if (reqAttr == pioc_pkg::ATTR_STATE) begin
              data_next = DW'(state_reg);
            end else begin
              ok_next = 1'b0;
            end
          end
        end
        pioc_pkg::OP_APPLY: begin
          if (state_reg == pioc_pkg::ST_CONFIG && !rateSet_reg &&
              rate_reg == pioc_pkg::PKT_RATE_RST[DW-1:0]) begin
            ok_next = 1'b1;
            state_next = pioc_pkg::ST_ESTAB;
          end
        end
        pioc_pkg::OP_TIMEOUT: begin
          if (state_reg == pioc_pkg::ST_ESTAB) begin
            ok_next = 1'b1;
            state_next = pioc_pkg::ST_TIMEOUT;
          end
        end
        pioc_pkg::OP_NOP: begin
          ok_next = 1'b0;
        end
      endcase
    end
  end

  assign leaveEst = state_reg == pioc_pkg::ST_ESTAB && state_next != pioc_pkg::ST_ESTAB;
  assign goRelease = leaveEst && autoRelease;

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= pioc_pkg::ST_NONEXIST;
    end else if (clkEn) begin
      if (goRelease) begin
        state_reg <= pioc_pkg::ST_NONEXIST;
      end else begin
        state_reg <= state_next;
      end
    end
  end

  // ****************************************
  // attributes
  // ****************************************
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rate_reg <= pioc_pkg::PKT_RATE_RST[DW-1:0];
      size_reg <= pioc_pkg::PROD_SIZE_RST[DW-1:0];
      rateSet_reg <= 1'b0;
    end else if (clkEn) begin
      if (resetAttr || goRelease) begin
        rate_reg <= pioc_pkg::PKT_RATE_RST[DW-1:0];
        size_reg <= pioc_pkg::PROD_SIZE_RST[DW-1:0];
        rateSet_reg <= 1'b0;
      end else begin
        if (wrRate) begin
          rate_reg <= reqData;
          rateSet_reg <= 1'b1;
        end
        if (wrSize) begin
          size_reg <= reqData;
        end
      end
    end
  end

  // ****************************************
  // response
  // ****************************************
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rspValid <= 1'b0;
      rspOk <= 1'b0;
      rspData <= '0;
      setReleased <= 1'b0;
    end else if (clkEn) begin
      rspValid <= reqValid && op != pioc_pkg::OP_NOP;
      rspOk <= ok_next;
      rspData <= data_next;
      setReleased <= goRelease;
    end
  end

  assign connState = state_reg;
  assign pktRate = rate_reg;

  // ****************************************
  // checks
  // ****************************************
  chk_set_commits: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clkEn && reqValid && op == pioc_pkg::OP_SET && reqAttr == pioc_pkg::ATTR_PKT_RATE &&
    state_reg == pioc_pkg::ST_CONFIG && !autoRelease |=> state_reg == pioc_pkg::ST_ESTAB)
    else $error("rate write did not establish");
  chk_apply_refused: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clkEn && reqValid && op == pioc_pkg::OP_APPLY && rateSet_reg |=> rspValid && !rspOk)
    else $error("commit accepted after rate set");
  chk_rate_default: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clkEn && reqValid && op == pioc_pkg::OP_ALLOC && (state_reg == pioc_pkg::ST_NONEXIST ||
    state_reg == pioc_pkg::ST_TIMEOUT) |=> rate_reg == '0 && !rateSet_reg)
    else $error("rate not defaulted");
  chk_auto_release: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clkEn && goRelease |=> state_reg == pioc_pkg::ST_NONEXIST && setReleased)
    else $error("set release failed");
  chk_always_answer: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clkEn && reqValid && op != pioc_pkg::OP_NOP |=> rspValid)
    else $error("request not answered");
  chk_release_reset: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clkEn && reqValid && op == pioc_pkg::OP_RELEASE &&
    state_reg != pioc_pkg::ST_NONEXIST |=> state_reg == pioc_pkg::ST_NONEXIST && size_reg == '0)
    else $error("release did not reset");
  chk_rate_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clkEn && wrRate && !goRelease |=> rate_reg == $past(reqData) && rateSet_reg)
    else $error("rate not written");
  chk_leave_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clkEn && reqValid && op == pioc_pkg::OP_TIMEOUT && state_reg == pioc_pkg::ST_ESTAB &&
    autoRelease |=> state_reg == pioc_pkg::ST_NONEXIST)
    else $error("leave not evaluated");
  chk_apply_commit: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clkEn && reqValid && op == pioc_pkg::OP_APPLY && state_reg == pioc_pkg::ST_CONFIG &&
    !rateSet_reg |=> rspOk && state_reg == pioc_pkg::ST_ESTAB)
    else $error("commit refused while rate unset");
  chk_release_pulse: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clkEn && !goRelease |=> !setReleased)
    else $error("set release flagged without cause");

endmodule // pioc_conn_fsm

// ---- pkg/pioc_pkg.sv ----
package pioc_pkg;
  // connection states
  typedef enum logic [1:0] {
    ST_NONEXIST = 2'b00,
    ST_CONFIG = 2'b01,
    ST_ESTAB = 2'b10,
    ST_TIMEOUT = 2'b11
  } pioc_state_t;

  // request opcodes
  typedef enum logic [2:0] {
    OP_SET = 3'b000,
    OP_GET = 3'b001,
    OP_APPLY = 3'b010,
    OP_ALLOC = 3'b011,
    OP_RELEASE = 3'b100,
    OP_DELETE = 3'b101,
    OP_TIMEOUT = 3'b110,
    OP_NOP = 3'b111
  } pioc_op_t;

  // attribute ids
  localparam logic [3:0] ATTR_STATE = 4'h1;
  localparam logic [3:0] ATTR_PKT_RATE = 4'h9;
  localparam logic [3:0] ATTR_PROD_SIZE = 4'h7;

  // values after reset
  localparam logic [15:0] PKT_RATE_RST = 16'h0000;
  localparam logic [15:0] PROD_SIZE_RST = 16'h0000;
endpackage

// ---- tb/pioc_conn_fsm_tb.sv ----
`timescale 1ns/1ps
module pioc_conn_fsm_tb;
  typedef struct packed {logic ok; logic chk; logic [15:0] rd; logic [1:0] st;
    logic rel;} pioc_note_t;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic clkEn = 1'b1;
  logic autoRelease = 1'b0;
  logic reqValid;
  logic [2:0] reqOp;
  logic [3:0] reqAttr;
  logic [15:0] reqData;
  logic rspValid;
  logic rspOk;
  logic [15:0] rspData;
  logic [1:0] connState;
  logic setReleased;
  logic [15:0] pktRate;
  logic [15:0] rate;
  pioc_note_t noteQ[$];
  pioc_note_t note;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed = 32'h81a9bd16;
  always #2 clk_sys = ~clk_sys;
  pioc_master_model master (.clk_sys(clk_sys), .reqValid(reqValid), .reqOp(reqOp),
    .reqAttr(reqAttr), .reqData(reqData));
  pioc_conn_fsm #(.DW(16)) DUT (.clk_sys(clk_sys), .reset_n(reset_n), .clkEn(clkEn),
    .reqValid(reqValid), .reqOp(reqOp), .reqAttr(reqAttr), .reqData(reqData),
    .autoRelease(autoRelease), .rspValid(rspValid), .rspOk(rspOk), .rspData(rspData),
    .connState(connState), .setReleased(setReleased), .pktRate(pktRate));
  task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic final_report();
    if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic req(input pioc_pkg::pioc_op_t op, input logic [3:0] a, input logic [15:0] d,
    input logic chk, input logic ok, input logic [15:0] rd, input logic [1:0] st, input logic rel);
    if (op != pioc_pkg::OP_NOP) noteQ.push_back(pioc_note_t'{ok, chk, rd, st, rel});
    master.issue(op, a, d);
  endtask
  task automatic chkRate(input logic [15:0] e);
    @(negedge clk_sys);
    cmp("pktRate", e, pktRate);
  endtask
  // ****************************************
  // response watcher
  // ****************************************
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      fail_count++;
      final_report();
    end
    if (rspValid === 1'b1) begin
      if (noteQ.size() == 0) cmp("rspValid", 16'h0000, 16'h0001);
      else begin
        note = noteQ.pop_front();
        if (note.chk) cmp("rspOk", 16'(note.ok), 16'(rspOk));
        cmp("rspData", note.rd, rspData);
        cmp("connState", 16'(note.st), 16'(connState));
        cmp("setReleased", 16'(note.rel), 16'(setReleased));
      end
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    chkRate(16'h0000);
    req(pioc_pkg::OP_NOP, 4'h0, 16'h0000, 1'b0, 1'b0, 16'h0000, 2'h0, 1'b0);
    req(pioc_pkg::OP_ALLOC, 4'h0, 16'h0000, 1'b1, 1'b1, 16'h0000, 2'h1, 1'b0);
    req(pioc_pkg::OP_GET, pioc_pkg::ATTR_PKT_RATE, 16'h0000,
      1'b1, 1'b1, 16'h0000, 2'h1, 1'b0);
    req(pioc_pkg::OP_ALLOC, 4'h0, 16'h0000, 1'b1, 1'b0, 16'h0000, 2'h1, 1'b0);
    req(pioc_pkg::OP_APPLY, 4'h0, 16'h0000, 1'b1, 1'b1, 16'h0000, 2'h2, 1'b0);
    rate = 16'($random(seed)) | 16'h0001;
    req(pioc_pkg::OP_SET, pioc_pkg::ATTR_PKT_RATE, rate, 1'b1, 1'b1, 16'h0000, 2'h2, 1'b0);
    req(pioc_pkg::OP_GET, pioc_pkg::ATTR_PKT_RATE, 16'h0000, 1'b1, 1'b1, rate, 2'h2, 1'b0);
    req(pioc_pkg::OP_APPLY, 4'h0, 16'h0000, 1'b1, 1'b0, 16'h0000, 2'h2, 1'b0);
    req(pioc_pkg::OP_SET, pioc_pkg::ATTR_PROD_SIZE, 16'h0003,
      1'b1, 1'b0, 16'h0000, 2'h2, 1'b0);
    req(pioc_pkg::OP_TIMEOUT, 4'h0, 16'h0000, 1'b1, 1'b1, 16'h0000, 2'h3, 1'b0);
    req(pioc_pkg::OP_ALLOC, 4'h0, 16'h0000, 1'b1, 1'b1, 16'h0000, 2'h1, 1'b0);
    chkRate(16'h0000);
    rate = 16'($random(seed)) | 16'h0001;
    req(pioc_pkg::OP_SET, pioc_pkg::ATTR_PKT_RATE, rate, 1'b1, 1'b1, 16'h0000, 2'h2, 1'b0);
    chkRate(rate);
    req(pioc_pkg::OP_APPLY, 4'h0, 16'h0000, 1'b1, 1'b0, 16'h0000, 2'h2, 1'b0);
    @(posedge clk_sys);
    autoRelease <= 1'b1;
    req(pioc_pkg::OP_TIMEOUT, 4'h0, 16'h0000, 1'b1, 1'b1, 16'h0000, 2'h0, 1'b1);
    chkRate(16'h0000);
    req(pioc_pkg::OP_RELEASE, 4'h0, 16'h0000, 1'b1, 1'b0, 16'h0000, 2'h0, 1'b0);
    req(pioc_pkg::OP_ALLOC, 4'h0, 16'h0000, 1'b1, 1'b1, 16'h0000, 2'h1, 1'b0);
    req(pioc_pkg::OP_SET, pioc_pkg::ATTR_PROD_SIZE, 16'h0005,
      1'b1, 1'b1, 16'h0000, 2'h1, 1'b0);
    req(pioc_pkg::OP_GET, pioc_pkg::ATTR_PROD_SIZE, 16'h0000,
      1'b1, 1'b1, 16'h0005, 2'h1, 1'b0);
    req(pioc_pkg::OP_GET, pioc_pkg::ATTR_STATE, 16'h0000,
      1'b1, 1'b1, 16'h0001, 2'h1, 1'b0);
    req(pioc_pkg::OP_GET, 4'h2, 16'h0000, 1'b1, 1'b0, 16'h0000, 2'h1, 1'b0);
    req(pioc_pkg::OP_RELEASE, 4'h0, 16'h0000, 1'b1, 1'b1, 16'h0000, 2'h0, 1'b0);
    req(pioc_pkg::OP_ALLOC, 4'h0, 16'h0000, 1'b1, 1'b1, 16'h0000, 2'h1, 1'b0);
    req(pioc_pkg::OP_DELETE, 4'h0, 16'h0000, 1'b1, 1'b1, 16'h0000, 2'h0, 1'b0);
    // request while frozen: not taken, no answer
    @(posedge clk_sys);
    clkEn <= 1'b0;
    master.issue(pioc_pkg::OP_ALLOC, 4'h0, 16'h0000);
    clkEn <= 1'b1;
    req(pioc_pkg::OP_GET, pioc_pkg::ATTR_PKT_RATE, 16'h0000,
      1'b1, 1'b0, 16'h0000, 2'h0, 1'b0);
    repeat (3) @(posedge clk_sys);
    cmp("pending", 16'h0000, 16'(noteQ.size()));
    final_report();
  end
endmodule // pioc_conn_fsm_tb

// ---- tb/pioc_master_model.sv ----
`timescale 1ns/1ps
// ****************************************
// network master issuing requests
// ****************************************
module pioc_master_model (
  input wire logic clk_sys,
  output logic reqValid,
  output logic [2:0] reqOp,
  output logic [3:0] reqAttr,
  output logic [15:0] reqData
);
  initial begin
    reqValid = 1'b0;
    reqOp = 3'h7;
    reqAttr = 4'h0;
    reqData = 16'h0000;
  end
  // one-cycle strobe; data scrambled once released
  task automatic issue(input pioc_pkg::pioc_op_t op, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reqValid <= 1'b1;
    reqOp <= op;
    reqAttr <= a;
    reqData <= d;
    @(posedge clk_sys);
    reqValid <= 1'b0;
    reqData <= ~d;
  endtask
endmodule // pioc_master_model
